// file: bench/usb_device_irq_status_tb_top.sv
// Purpose: self-checking bench for the usb interrupt status block
// Assumes: suspend detect shortened to 20 cycles
// Notes: answers sampled at the falling edge to avoid races
`timescale 1ns/100ps
module usb_device_irq_status_tb_top;
	localparam logic [7:0] EN = usb_irq_pkg::OFS_IRQ_ENABLE;
	localparam logic [7:0] ST = usb_irq_pkg::OFS_IRQ_STATUS;
	localparam logic [7:0] FC = usb_irq_pkg::OFS_FRAME_COUNT;
	localparam logic [31:0] SLV = 32'(usb_irq_pkg::RESP_SLVERR);
	localparam logic [4:0] PM [4] = '{5'h01, 5'h02, 5'h04, 5'h10};
	localparam logic [31:0] SB [4] = '{32'h0000_0004, 32'h0000_0008, 32'h0000_0010,
		32'h0000_0040};
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	logic ce_in = 1'b1;
	usb_irq_pkg::usb_evt_s evt_in;
	logic [6:0] ept_src_in = 7'h00;
	logic [5:0] dma_src_in = 6'h00;
	logic [7:0] s_axi_awaddr_in = 8'h00;
	logic [7:0] s_axi_araddr_in = 8'h00;
	logic [31:0] s_axi_wdata_in = 32'h0000_0000;
	logic s_axi_awvalid_in = 1'b0;
	logic s_axi_wvalid_in = 1'b0;
	logic s_axi_bready_in = 1'b0;
	logic s_axi_arvalid_in = 1'b0;
	logic s_axi_rready_in = 1'b0;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out, irq_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, resp;
	logic [31:0] s_axi_rdata_out, v;
	int miscompares = 0;
	int n_tests = 0;
	// 25 MHz clock
	always #20 clk_sys_in = ~clk_sys_in;
	usb_host_model host (.clk_sys_in, .evt_out(evt_in));
	usb_device_irq_status #(.SUSPEND_CYCLES(20)) uut (.clk_sys_in, .resetn_in, .ce_in, .evt_in,
		.ept_src_in, .dma_src_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
		.s_axi_wdata_in, .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in, .s_axi_wready_out,
		.s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
		.s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
		.s_axi_rvalid_out, .s_axi_rready_in, .irq_out);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// both channels offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk_sys_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do begin
			@(negedge clk_sys_in);
			ta = s_axi_awready_out;
			tw = s_axi_wready_out;
			tb = s_axi_bvalid_out;
			resp = s_axi_bresp_out;
			@(posedge clk_sys_in);
			if (ta) s_axi_awvalid_in <= 1'b0;
			if (tw) s_axi_wvalid_in <= 1'b0;
		end while (!tb);
		s_axi_bready_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, tv;
		@(posedge clk_sys_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do begin
			@(negedge clk_sys_in);
			ta = s_axi_arready_out;
			tv = s_axi_rvalid_out;
			v = s_axi_rdata_out;
			resp = s_axi_rresp_out;
			@(posedge clk_sys_in);
			if (ta) s_axi_arvalid_in <= 1'b0;
		end while (!tv);
		s_axi_rready_in <= 1'b0;
	endtask
	// irq is registered behind the flag, so give it two edges
	task automatic irq_is(input logic e);
		repeat (2) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		chk(32'(irq_out), 32'(e));
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		rd(EN);
		chk(v, usb_irq_pkg::ENABLE_RESET);
		wr(EN, 32'h7E00_7FFE);
		chk(32'(resp), 32'h0000_0000);
		rd(EN);
		chk(v, 32'h7E00_7FFE);
		host.lvl(1'b1, 1'b0, 1'b0);
		rd(ST);
		chk(v, 32'h0000_0001);
		host.lvl(1'b0, 1'b0, 1'b0);
		rd(ST);
		chk(v, 32'h0000_0000);
		// a zero clear must leave the flag, a one must drop it
		for (int i = 0; i < 4; i++) begin
			host.pulse(PM[i], 11'h000);
			irq_is(1'b1);
			wr(usb_irq_pkg::OFS_IRQ_CLEAR, ~SB[i] & 32'h0000_00FE);
			irq_is(1'b1);
			wr(usb_irq_pkg::OFS_IRQ_CLEAR, SB[i]);
			irq_is(1'b0);
			host.pulse(PM[i], 11'h000);
			rd(ST);
			chk(v, SB[i]);
		end
		$display("test events done");
		host.lvl(1'b1, 1'b0, 1'b0);
		host.pulse(5'h03, 11'h123);
		rd(ST);
		chk(v, 32'h0000_0009);
		for (int i = 0; i < 3; i++) host.pulse(5'h01, 11'h000);
		rd(FC);
		chk(v, 32'h0000_091B);
		host.pulse(5'h02, 11'h7FF);
		rd(FC);
		chk(v, 32'h0000_3FF8);
		host.lvl(1'b0, 1'b1, 1'b0);
		repeat (22) @(posedge clk_sys_in);
		host.lvl(1'b0, 1'b0, 1'b0);
		rd(ST);
		chk(v, 32'h0000_000E);
		ce_in <= 1'b0;
		host.pulse(5'h08, 11'h000);
		irq_is(1'b1);
		@(posedge clk_sys_in);
		ce_in <= 1'b1;
		rd(ST);
		chk(v, 32'h0000_0020);
		host.lvl(1'b0, 1'b0, 1'b1);
		rd(ST);
		chk(v, 32'h0000_0080);
		host.lvl(1'b0, 1'b0, 1'b0);
		rd(ST);
		chk(v, 32'h0000_0080);
		// a sof landing on the edge of a clear write must survive it
		fork
			wr(usb_irq_pkg::OFS_IRQ_CLEAR, 32'h0000_0008);
			begin
				@(posedge clk_sys_in);
				host.pulse(5'h02, 11'h000);
			end
		join
		rd(ST);
		chk(v, 32'h0000_0008);
		$display("test frame and suspend done");
		wr(EN, 32'h0000_0000);
		host.pulse(5'h04, 11'h000);
		rd(EN);
		chk(v, 32'h0000_0010);
		wr(EN, 32'h0000_0000);
		ept_src_in <= 7'h7F;
		dma_src_in <= 6'h3F;
		irq_is(1'b0);
		rd(ST);
		chk(v, 32'h0000_0010);
		wr(EN, 32'h7E00_7F00);
		rd(ST);
		chk(v, 32'h7E00_7F00);
		irq_is(1'b1);
		wr(usb_irq_pkg::OFS_IRQ_CLEAR, 32'h7E00_7FFE);
		rd(ST);
		chk(v, 32'h7E00_7F00);
		ept_src_in <= 7'h00;
		dma_src_in <= 6'h00;
		rd(ST);
		chk(v, 32'h0000_0000);
		irq_is(1'b0);
		rd(8'h20);
		chk(32'(resp), SLV);
		wr(ST, 32'h0000_00FE);
		chk(32'(resp), SLV);
		$display("test masks and access done");
		give_verdict();
	end
	// watchdog far beyond the expected run of under a thousand cycles
	initial begin
		#200000;
		miscompares++;
		give_verdict();
	end
endmodule // usb_device_irq_status_tb_top

// file: bench/usb_host_model.sv
// Purpose: protocol engine stand-in that raises usb bus events
// Assumes: tasks are called from the bench main sequence
// Notes: frame number is scrambled once its sof pulse is over
`timescale 1ns/100ps
module usb_host_model (
	input wire logic clk_sys_in,
	output usb_irq_pkg::usb_evt_s evt_out
);
	initial evt_out = '0;
	// bus levels: speed, idle J, remote resume
	task automatic lvl(input logic hs, input logic j, input logic rr);
		@(posedge clk_sys_in);
		evt_out.high_speed <= hs;
		evt_out.bus_idle_j <= j;
		evt_out.remote_resume <= rr;
	endtask
	// one-cycle pulses: micro sof, sof, reset done, line activity, host resume done
	task automatic pulse(input logic [4:0] m, input logic [10:0] fn);
		@(posedge clk_sys_in);
		{evt_out.host_resume_done, evt_out.line_activity,
			evt_out.bus_reset_done} <= m[4:2];
		{evt_out.sof, evt_out.micro_sof} <= m[1:0];
		evt_out.frame_num <= fn;
		@(posedge clk_sys_in);
		{evt_out.host_resume_done, evt_out.line_activity, evt_out.bus_reset_done} <= 3'h0;
		{evt_out.sof, evt_out.micro_sof} <= 2'h0;
		evt_out.frame_num <= ~fn;
	endtask
endmodule // usb_host_model

// file: bench/usb_irq_assertions.sv
// Purpose: port checks for the usb interrupt status block
// Assumes: read address is kept from the edge that accepts it
// Notes: speed bit is judged only while its input holds steady
`timescale 1ns/100ps
module usb_irq_assertions (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire usb_irq_pkg::usb_evt_s evt_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0] s_axi_rresp_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	logic [7:0] ra;
	logic st;
	logic um;
	// address of the read in flight
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) ra <= 8'h00;
		else if (s_axi_arvalid_in && !s_axi_rvalid_out && ce_in) ra <= s_axi_araddr_in;
	end
	// decode of the held address
	assign st = ra == usb_irq_pkg::OFS_IRQ_STATUS;
	assign um = !(ra inside {usb_irq_pkg::OFS_FRAME_COUNT, usb_irq_pkg::OFS_IRQ_ENABLE,
		usb_irq_pkg::OFS_IRQ_STATUS, usb_irq_pkg::OFS_IRQ_CLEAR});
	AST_ARLAT: assert property (s_axi_arvalid_in && !s_axi_rvalid_out && ce_in
		|=> s_axi_rvalid_out) else $error("read answer late");
	AST_RHOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer lost");
	AST_RDONE: assert property (s_axi_rvalid_out && s_axi_rready_in && ce_in
		|=> !s_axi_rvalid_out) else $error("read answer repeated");
	AST_BHOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
		else $error("write answer lost");
	AST_RBUSY: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read taken while busy");
	AST_SPEED: assert property ($rose(s_axi_rvalid_out) && st
		&& $past(evt_in.high_speed, 1) == $past(evt_in.high_speed, 2)
		|-> s_axi_rdata_out[0] == $past(evt_in.high_speed, 1)) else $error("speed bit wrong");
	AST_RSVD: assert property (s_axi_rvalid_out && st |->
		s_axi_rdata_out[31] == 1'b0 && s_axi_rdata_out[24:15] == 10'h000)
		else $error("unused status bit set");
	AST_UNMAP: assert property (s_axi_rvalid_out && um |-> s_axi_rdata_out == 32'h0000_0000
		&& s_axi_rresp_out == usb_irq_pkg::RESP_SLVERR) else $error("unmapped read accepted");
	cover property ($rose(s_axi_bvalid_out));
	cover property (s_axi_rvalid_out && st);
	cover property (s_axi_rvalid_out && um);
endmodule // usb_irq_assertions
bind usb_device_irq_status usb_irq_assertions chk (.clk_sys_in, .resetn_in, .ce_in, .evt_in,
	.s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_bvalid_out,
	.s_axi_bready_in, .s_axi_rvalid_out, .s_axi_rready_in, .s_axi_rdata_out, .s_axi_rresp_out);

// file: include/usb_irq_pkg.sv
// Purpose: constants and carriers for the usb device interrupt status block
// Assumes: 25 MHz system clock, 32-bit AXI4-Lite register port
// Notes: Notes on behaviour listed below
// Notes on behaviour
// RQ1 - speed bit 0 reads 1 in high speed
// RQ2 - suspend flag after 3 ms idle J
// RQ3 - flag interrupts only when enable bit set
// RQ4 - micro-frame flag on each micro start-of-frame
// RQ5 - micro start-of-frame increments microframe, keeps frame
// RQ6 - micro and frame flags never same event
// RQ7 - frame flag on each start-of-frame token
// RQ8 - high speed frame: clear microframe, load frame
// RQ9 - reset-done flag at end of bus reset
// RQ10 - wake flag on line activity, clock stopped
// RQ11 - software restarts controller clock after wake
// RQ12 - host resume done flag on resume end
// RQ13 - remote resume flag while sending resume
// RQ14 - endpoint flags follow enabled endpoint sources
// RQ15 - dma flags follow enabled channel sources
// RQ16 - write one clears event flags 1 to 7
// RQ17 - dma enable bits writable and readable
// RQ18 - reset-done enable set after bus reset
// RQ19 - simultaneous set and clear keeps flag set
package usb_irq_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_FRAME_COUNT = 8'h04;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;

	// status, enable and clear bit layout
	localparam int BIT_SPEED = 0;
	localparam int BIT_SUSPEND = 1;
	localparam int BIT_MICRO_SOF = 2;
	localparam int BIT_SOF = 3;
	localparam int BIT_RESET_DONE = 4;
	localparam int BIT_WAKE = 5;
	localparam int BIT_RESUME_DONE = 6;
	localparam int BIT_REMOTE_RESUME = 7;
	localparam int EVT_LO = 1;
	localparam int EVT_HI = 7;
	localparam int EPT_LO = 8;
	localparam int EPT_SLOTS = 7;
	localparam int DMA_LO = 25;
	localparam int DMA_SLOTS = 6;

	// frame count register layout
	localparam int MICRO_LO = 0;
	localparam int FRAME_LO = 3;
	localparam int FRAME_W = 11;
	localparam int MICRO_W = 3;

	// reset values
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// timing: suspend detect after idle J for this long
	localparam int CLK_KHZ = 25000;
	localparam int SUSPEND_TIME_US = 3000;
	localparam int SUSPEND_CYCLES = (SUSPEND_TIME_US * CLK_KHZ) / 1000;

	// link power state
	typedef enum logic [1:0] {
		pm_active = 2'b01,
		pm_suspended = 2'b10
	} pm_state_e;

	// events reported by the usb protocol engine, synchronous to the clock
	typedef struct packed {
		logic high_speed;
		logic bus_idle_j;
		logic micro_sof;
		logic sof;
		logic [FRAME_W-1:0] frame_num;
		logic bus_reset_done;
		logic line_activity;
		logic host_resume_done;
		logic remote_resume;
	} usb_evt_s;

endpackage

// file: verilog/usb_device_irq_status.sv
// Purpose: interrupt flags, enables and clear logic of a high speed usb device controller
// Assumes: protocol engine events are synchronous single-cycle pulses or levels
// Notes: registers reached over AXI4-Lite; one level interrupt output
`timescale 1ns/100ps

module usb_device_irq_status #(
	parameter int SUSPEND_CYCLES = usb_irq_pkg::SUSPEND_CYCLES,
	parameter int N_EPT = usb_irq_pkg::EPT_SLOTS,
	parameter int N_DMA = usb_irq_pkg::DMA_SLOTS
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire usb_irq_pkg::usb_evt_s evt_in,
	input wire logic [N_EPT-1:0] ept_src_in,
	input wire logic [N_DMA-1:0] dma_src_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic irq_out
);

	localparam int CNT_W = $clog2(SUSPEND_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SUSPEND_CYCLES - 1);

	// register map, byte offsets on the 8-bit bus address
	//   each register is one aligned 32-bit word
	//   0x04 frame count  read only: [2:0] microframe, [13:3] frame of the last sof
	//   0x10 enable       read/write: one bit per status bit, bit 0 unused
	//   0x14 status       read only: speed, sticky events 1..7, endpoint and dma levels
	//   0x18 clear        write only: a one on bits 1..7 drops that event flag
	//   anything else answers with a slave error; reads of it return zero
	// status bit layout
	//   bit 0 high speed, bit 1 suspend, bit 2 micro sof, bit 3 sof
	//   bit 4 bus reset done, bit 5 wake-up, bit 6 host resume done
	//   bit 7 remote resume, bits 8..14 endpoints, bits 25..30 dma channels 1..6
	// bus timing seen from the master
	//   a write answers two edges after address and data are both offered
	//   a read answers one edge after its address is offered, on the same edge that takes it
	//   a status read clears events 1..7; the word returned is the one before
	// hazards and limitations
	//   an event in the cycle of its clear keeps the flag, so nothing is lost
	//   only byte lane 0 of a clear write counts; the other lanes hold nothing
	//   endpoint and dma bits follow their sources and are cleared there
	//   the clock enable stalls the bus; only the wake flag and irq keep running
	//   the suspend span is counted in clocks, so a slower clock needs a new
	//   SUSPEND_CYCLES value

	// refuse shapes the register layout cannot hold
	// endpoint and dma fields have fixed room in the status word
	if (SUSPEND_CYCLES < 1 || N_EPT < 1 || N_EPT > usb_irq_pkg::EPT_SLOTS ||
		N_DMA < 1 || N_DMA > usb_irq_pkg::DMA_SLOTS) begin : g_bad_params
		$error("usb_device_irq_status: parameter out of range");
	end

	// reset copy, power state and suspend counter
	logic [1:0] rst_sync;
	logic rst_n;
	usb_irq_pkg::pm_state_e pm_state;
	logic [CNT_W-1:0] idle_cnt;

	// status flags, enables and frame numbering
	logic speed_hs;
	logic [usb_irq_pkg::EVT_HI:usb_irq_pkg::EVT_LO] ev_flags;
	logic wake_flag;
	logic [N_EPT-1:0] ept_flags;
	logic [N_DMA-1:0] dma_flags;
	logic [31:0] irq_enable;
	logic [usb_irq_pkg::FRAME_W-1:0] frame_num;
	logic [usb_irq_pkg::MICRO_W-1:0] micro_num;

	// write halves parked until both are in
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// combinational terms
	logic wr_fire;
	logic rd_fire;
	logic suspend_hit;
	logic wake_hit;
	logic [usb_irq_pkg::EVT_HI:usb_irq_pkg::EVT_LO] ev_set;
	logic [usb_irq_pkg::EVT_HI:usb_irq_pkg::EVT_LO] ev_clr;
	logic [31:0] status_word;
	logic [31:0] frame_word;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// reset release through two flops; assertion stays asynchronous
	// so no flop leaves reset on the edge that also samples an input
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// bus handshakes: one write and one read at a time; readies drop while the
	// clock enable is low, since a frozen slave must not show a handshake that
	// it cannot take
	assign s_axi_awready_out = ce_in && !aw_held;
	assign s_axi_wready_out = ce_in && !w_held;
	assign s_axi_arready_out = ce_in && !s_axi_rvalid_out;
	assign wr_fire = ce_in && aw_held && w_held && !s_axi_bvalid_out;
	assign rd_fire = ce_in && s_axi_arvalid_in && !s_axi_rvalid_out;

	// write address and data may arrive in either order
	// the halves are parked here so the master may release each once taken
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (ce_in) begin
			if (s_axi_awvalid_in && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_in;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid_in && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_in;
				w_strb <= s_axi_wstrb_in;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	// write response; read-only and unmapped words answer with an error
	// the response waits for bready, so a slow master loses nothing
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= usb_irq_pkg::RESP_OKAY;
		end else if (ce_in) begin
			if (wr_fire) begin
				s_axi_bvalid_out <= 1'b1;
				if (aw_addr == usb_irq_pkg::OFS_IRQ_ENABLE || aw_addr == usb_irq_pkg::OFS_IRQ_CLEAR) begin
					s_axi_bresp_out <= usb_irq_pkg::RESP_OKAY;
				end else begin
					s_axi_bresp_out <= usb_irq_pkg::RESP_SLVERR;
				end
			end else if (s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	// read word assembly
	// decoded from the live read address; only used on the accepting edge
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[usb_irq_pkg::BIT_SPEED] = speed_hs; // RQ1
		status_word[usb_irq_pkg::EVT_HI:usb_irq_pkg::EVT_LO] = ev_flags;
		status_word[usb_irq_pkg::BIT_WAKE] = wake_flag;
		status_word[usb_irq_pkg::EPT_LO +: N_EPT] = ept_flags;
		status_word[usb_irq_pkg::DMA_LO +: N_DMA] = dma_flags;
		frame_word = 32'h0000_0000;
		frame_word[usb_irq_pkg::MICRO_LO +: usb_irq_pkg::MICRO_W] = micro_num;
		frame_word[usb_irq_pkg::FRAME_LO +: usb_irq_pkg::FRAME_W] = frame_num;
		next_rresp = usb_irq_pkg::RESP_OKAY;
		case (s_axi_araddr_in)
			usb_irq_pkg::OFS_IRQ_STATUS: next_rdata = status_word;
			usb_irq_pkg::OFS_IRQ_ENABLE: next_rdata = irq_enable; // RQ17
			usb_irq_pkg::OFS_FRAME_COUNT: next_rdata = frame_word;
			default: begin
				next_rdata = 32'h0000_0000;
				next_rresp = usb_irq_pkg::RESP_SLVERR;
			end
		endcase
	end

	// read data channel, registered
	// data are frozen while rvalid stands, so a stalled master sees one word
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= usb_irq_pkg::RDATA_RESET;
			s_axi_rresp_out <= usb_irq_pkg::RESP_OKAY;
		end else if (ce_in) begin
			if (rd_fire) begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out <= next_rdata;
				s_axi_rresp_out <= next_rresp;
			end else if (s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
	end

	// enable register; byte lanes honoured, bus reset end re-arms its enable
	// the re-arm comes after the write lanes, so it wins a same-cycle write
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			irq_enable <= usb_irq_pkg::ENABLE_RESET;
		end else if (ce_in) begin
			if (wr_fire && aw_addr == usb_irq_pkg::OFS_IRQ_ENABLE) begin
				for (int i = 0; i < 4; i++) begin
					if (w_strb[i]) begin
						irq_enable[i*8 +: 8] <= w_data[i*8 +: 8]; // RQ17
					end
				end
			end
			if (evt_in.bus_reset_done) begin
				irq_enable[usb_irq_pkg::BIT_RESET_DONE] <= 1'b1; // RQ18
			end
		end
	end

	// speed status follows the engine's current mode
	// one flop of delay keeps the status word in step with the event flags
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			speed_hs <= 1'b0;
		end else if (ce_in) begin
			speed_hs <= evt_in.high_speed; // RQ1
		end
	end

	// idle J counter; counting stops once suspended so the flag fires once
	// any non-J cycle restarts the count; the span is SUSPEND_CYCLES clocks
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			idle_cnt <= '0;
		end else if (ce_in) begin
			if (!evt_in.bus_idle_j || pm_state != usb_irq_pkg::pm_active || suspend_hit) begin
				idle_cnt <= '0;
			end else begin
				idle_cnt <= idle_cnt + 1'b1;
			end
		end
	end
	assign suspend_hit = evt_in.bus_idle_j && pm_state == usb_irq_pkg::pm_active &&
		idle_cnt == CNT_LAST; // RQ2

	// wake only from line activity, never from our own upstream resume
	// the power state is frozen with the clock enable, so it still gates this
	assign wake_hit = pm_state == usb_irq_pkg::pm_suspended && evt_in.line_activity &&
		!evt_in.remote_resume; // RQ10

	// link power state
	// a bus reset end also leaves suspend, since the host restarts the link
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			pm_state <= usb_irq_pkg::pm_active;
		end else if (ce_in) begin
			case (pm_state)
				usb_irq_pkg::pm_active: begin
					if (suspend_hit) begin
						pm_state <= usb_irq_pkg::pm_suspended;
					end
				end
				usb_irq_pkg::pm_suspended: begin
					if (evt_in.line_activity || evt_in.bus_reset_done) begin
						pm_state <= usb_irq_pkg::pm_active;
					end
				end
				default: pm_state <= usb_irq_pkg::pm_active;
			endcase
		end
	end

	// frame and microframe numbering
	// a sof outranks a micro sof in the same cycle; microframe wraps at eight
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			frame_num <= '0;
			micro_num <= '0;
		end else if (ce_in) begin
			if (evt_in.sof) begin
				frame_num <= evt_in.frame_num; // RQ8
				if (evt_in.high_speed) begin
					micro_num <= '0; // RQ8
				end
			end else if (evt_in.micro_sof) begin
				micro_num <= micro_num + 1'b1; // RQ5
			end
		end
	end

	// event set and clear terms; a status read also clears, as the bus expects
	// the read clear takes every event bit, wake included
	always_comb begin
		ev_set = '0;
		ev_set[usb_irq_pkg::BIT_SUSPEND] = suspend_hit; // RQ2
		ev_set[usb_irq_pkg::BIT_MICRO_SOF] = evt_in.micro_sof && !evt_in.sof; // RQ4 RQ6
		ev_set[usb_irq_pkg::BIT_SOF] = evt_in.sof; // RQ7
		ev_set[usb_irq_pkg::BIT_RESET_DONE] = evt_in.bus_reset_done; // RQ9
		ev_set[usb_irq_pkg::BIT_RESUME_DONE] = evt_in.host_resume_done; // RQ12
		ev_set[usb_irq_pkg::BIT_REMOTE_RESUME] = evt_in.remote_resume; // RQ13
		ev_clr = '0;
		if (wr_fire && aw_addr == usb_irq_pkg::OFS_IRQ_CLEAR && w_strb[0]) begin
			ev_clr = w_data[usb_irq_pkg::EVT_HI:usb_irq_pkg::EVT_LO]; // RQ16
		end
		if (rd_fire && s_axi_araddr_in == usb_irq_pkg::OFS_IRQ_STATUS) begin
			ev_clr = '1;
		end
	end

	// sticky event flags; set wins over clear (bit 5 lives in wake_flag)
	// a set in the cycle of a clear keeps the flag, so no event is lost
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			ev_flags <= '0;
		end else if (ce_in) begin
			ev_flags <= ((ev_flags & ~ev_clr) | ev_set) &
				~(7'(1) << (usb_irq_pkg::BIT_WAKE - usb_irq_pkg::EVT_LO)); // RQ19
		end
	end

	// wake flag keeps running while the clock enable is low, so a
	// suspended controller with its clock gated still sees the wake-up
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			wake_flag <= 1'b0;
		end else if (wake_hit) begin
			wake_flag <= 1'b1; // RQ10 RQ19
		end else if (ev_clr[usb_irq_pkg::BIT_WAKE]) begin
			wake_flag <= 1'b0; // RQ16
		end
	end

	// endpoint and dma flags track their enabled sources; not clearable here
	// software clears them at the source; one flop keeps irq timing even
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			ept_flags <= '0;
			dma_flags <= '0;
		end else if (ce_in) begin
			ept_flags <= ept_src_in & irq_enable[usb_irq_pkg::EPT_LO +: N_EPT]; // RQ14
			dma_flags <= dma_src_in & irq_enable[usb_irq_pkg::DMA_LO +: N_DMA]; // RQ15
		end
	end

	// one level interrupt, gated bit by bit by the enable register
	// left ungated by the clock enable so a wake-up reaches the processor
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(status_word & irq_enable &
				~(32'h0000_0001 << usb_irq_pkg::BIT_SPEED)); // RQ3
		end
	end

endmodule // usb_device_irq_status
